// *** core/pci_dma_chain_engine.sv ***
`timescale 1ns/10ps
`default_nettype none
module pci_dma_chain_engine (
  // clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // register bus, axi4-lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // system-bus master
  output var pci_dma_pkg::sys_req_t sysReq,
  input wire pci_dma_pkg::sys_rsp_t sysRsp,
  // pci side, asynchronous to clk_sys
  output var pci_dma_pkg::pci_req_t pciReq,
  input wire pci_dma_pkg::pci_in_t pciIn,
  // interrupt
  output logic irq
);

  function automatic logic [31:0] mergeBytes(input logic [31:0] old,
      input logic [31:0] val, input logic [3:0] strb);
    for (int i = 0; i < 4; i++) begin
      mergeBytes[8*i +: 8] = strb[i] ? val[8*i +: 8] : old[8*i +: 8];
    end
  endfunction

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    return a[7:2] == off[7:2];
  endfunction

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  pci_dma_pkg::dma_state_t state;
  logic ctrlRst, ctrlDir, xIe, cIe, eIe, active, chainRun, chainEnd;
  logic [1:0] ctrlMode;
  logic [4:0] errBits;
  logic xDone, cDone;
  logic [31:0] sysAddr, pciAddr, count, chainAddr, descBase;
  logic [4:0] beat, fifoCount;
  logic [31:0] fifo [16];
  pci_dma_pkg::pci_in_t pciMeta, pciSync;
  logic pciClkPrev, pciWaitLow;
  logic [7:0] wAddrQ;
  logic [31:0] wDataQ;
  logic [3:0] wStrbQ;

  // ------------------------------------------------------------
  // pci input synchroniser
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    pciMeta <= pciIn;
    pciSync <= pciMeta;
    pciClkPrev <= pciSync.clk;
  end

  // ------------------------------------------------------------
  // decode
  // ------------------------------------------------------------
  wire pciEdge = pciSync.clk && !pciClkPrev;
  wire inXfer = (state == pci_dma_pkg::ST_READ) ||
                (state == pci_dma_pkg::ST_WRITE);
  wire curPci = (state == pci_dma_pkg::ST_READ) ? ctrlDir :
                inXfer && !ctrlDir;
  wire sysBeat = sysReq.valid && sysRsp.ack;
  wire pciBeat = pciReq.req && pciSync.ack && pciEdge;
  wire busy = (state != pci_dma_pkg::ST_IDLE);
  wire beatDone = busy && (sysBeat || pciBeat);
  wire beatErr = busy && ((sysBeat && sysRsp.err) ||
                          (pciBeat && (|pciSync.err)));
  wire [31:0] rdWord = pciBeat ? pciSync.rdata : sysRsp.rdata;
  wire burstMode = (ctrlMode == pci_dma_pkg::MODE_BURST);
  wire [4:0] chunkLen = !burstMode ? pci_dma_pkg::SINGLE_WORDS :
      (count >= {27'h0, pci_dma_pkg::BURST_WORDS}) ?
      pci_dma_pkg::BURST_WORDS : count[4:0];
  wire lastBeat = (state == pci_dma_pkg::ST_FETCH) ?
      (beat == pci_dma_pkg::DESC_LAST_BEAT) :
      (beat == chunkLen - pci_dma_pkg::SINGLE_WORDS);
  wire [4:0] wantLeft = chunkLen - beat;
  wire spaceOk = (state == pci_dma_pkg::ST_READ) ?
      (pci_dma_pkg::FIFO_DEPTH - fifoCount >= wantLeft) :
      (fifoCount >= wantLeft);
  wire chunkDone = beatDone && !beatErr && lastBeat;
  wire zeroXfer = (state == pci_dma_pkg::ST_READ) && (count == 32'h0);
  wire finishEv = zeroXfer || ((state == pci_dma_pkg::ST_WRITE) &&
                  chunkDone && (count == {27'h0, chunkLen}));
  wire goFetch = chainRun && !chainEnd;
  wire needBus = (state == pci_dma_pkg::ST_FETCH) ||
                 (inXfer && !zeroXfer && spaceOk);
  wire sysIssue = needBus && !curPci && !sysReq.valid;
  wire pciIssue = needBus && curPci && !pciReq.req && !pciWaitLow &&
                  pciEdge;
  wire [1:0] descIdx = beat[1:0];

  // register bus decode
  wire doWrite = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
  wire wrCtrl = doWrite && hit(wAddrQ, pci_dma_pkg::OFF_CTRL);
  wire wrStat = doWrite && hit(wAddrQ, pci_dma_pkg::OFF_STATUS);
  wire wrSys = doWrite && hit(wAddrQ, pci_dma_pkg::OFF_SYSADDR) && !busy;
  wire wrPci = doWrite && hit(wAddrQ, pci_dma_pkg::OFF_PCIADDR) && !busy;
  wire wrCnt = doWrite && hit(wAddrQ, pci_dma_pkg::OFF_COUNT) && !busy;
  wire wrChain = doWrite && hit(wAddrQ, pci_dma_pkg::OFF_CHAIN) && !busy;
  wire wMapped = hit(wAddrQ, pci_dma_pkg::OFF_CTRL) ||
      hit(wAddrQ, pci_dma_pkg::OFF_STATUS) ||
      hit(wAddrQ, pci_dma_pkg::OFF_SYSADDR) ||
      hit(wAddrQ, pci_dma_pkg::OFF_PCIADDR) ||
      hit(wAddrQ, pci_dma_pkg::OFF_COUNT) ||
      hit(wAddrQ, pci_dma_pkg::OFF_CHAIN);
  wire [31:0] ctrlWord = {21'h0, eIe, cIe, xIe, 2'h0, chainRun, active,
                          ctrlMode, ctrlDir, ctrlRst};
  wire [31:0] statWord = {22'h0, cDone, xDone, 3'h0, errBits};
  wire [31:0] ctrlNew = mergeBytes(ctrlWord, wDataQ, wStrbQ);
  wire [31:0] w1c = mergeBytes(32'h0, wDataQ, wStrbQ);
  wire [31:0] chainNew = mergeBytes(chainAddr, wDataQ, wStrbQ);
  wire idleOk = !busy && !ctrlRst;
  wire startXfer = wrCtrl && ctrlNew[pci_dma_pkg::CTRL_ACT] && idleOk &&
                   !ctrlNew[pci_dma_pkg::CTRL_RST];
  wire startChain = wrChain && idleOk && (chainNew != 32'h0);
  wire [31:0] rdMux =
      hit(s_axi_araddr, pci_dma_pkg::OFF_CTRL) ? ctrlWord :
      hit(s_axi_araddr, pci_dma_pkg::OFF_STATUS) ? statWord :
      hit(s_axi_araddr, pci_dma_pkg::OFF_SYSADDR) ? sysAddr :
      hit(s_axi_araddr, pci_dma_pkg::OFF_PCIADDR) ? pciAddr :
      hit(s_axi_araddr, pci_dma_pkg::OFF_COUNT) ? count :
      hit(s_axi_araddr, pci_dma_pkg::OFF_CHAIN) ? chainAddr : 32'h0;
  wire rMapped = s_axi_araddr[7:2] <= pci_dma_pkg::OFF_CHAIN[7:2];
  wire [4:0] errSet = !beatErr ? 5'h0 :
      pciBeat ? {pciSync.err, 2'h0} :
      (state == pci_dma_pkg::ST_FETCH) ? 5'h02 : 5'h01;

  // ------------------------------------------------------------
  // axi4-lite slave
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= pci_dma_pkg::RESP_OKAY;
      wAddrQ <= 8'h00;
      wDataQ <= 32'h0;
      wStrbQ <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        wAddrQ <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wDataQ <= s_axi_wdata;
        wStrbQ <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (doWrite) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wMapped ? pci_dma_pkg::RESP_OKAY :
                                 pci_dma_pkg::RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= pci_dma_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rdMux;
      s_axi_rresp <= rMapped ? pci_dma_pkg::RESP_OKAY :
                               pci_dma_pkg::RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // ------------------------------------------------------------
  // control, status and interrupt
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      ctrlRst <= pci_dma_pkg::CTRL_RST_INIT;
      {ctrlDir, ctrlMode, xIe, cIe, eIe} <= 6'h00;
    end else if (wrCtrl) begin
      ctrlRst <= ctrlNew[pci_dma_pkg::CTRL_RST];
      ctrlDir <= ctrlNew[pci_dma_pkg::CTRL_DIR];
      ctrlMode <= ctrlNew[pci_dma_pkg::CTRL_MODE +: 2];
      xIe <= ctrlNew[pci_dma_pkg::CTRL_XIE];
      cIe <= ctrlNew[pci_dma_pkg::CTRL_CIE];
      eIe <= ctrlNew[pci_dma_pkg::CTRL_EIE];
    end
  end

  // a hardware set in the same cycle as a clear wins
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      {xDone, cDone, errBits} <= 7'h00;
      irq <= 1'b0;
    end else begin
      xDone <= (xDone && !(wrStat && w1c[pci_dma_pkg::ST_XDONE])) ||
               finishEv;
      cDone <= (cDone && !(wrStat && w1c[pci_dma_pkg::ST_CDONE])) ||
               (finishEv && chainRun && chainEnd);
      errBits <= (errBits & ~(wrStat ? w1c[4:0] : 5'h0)) | errSet;
      irq <= (xDone && xIe) || (cDone && cIe) ||
             ((|errBits) && eIe);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn || ctrlRst) begin
      active <= 1'b0;
      chainRun <= 1'b0;
    end else if (startXfer || startChain) begin
      active <= 1'b1;
      chainRun <= startChain;
    end else if (beatErr || (finishEv && !goFetch)) begin
      active <= 1'b0;
      chainRun <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // channel registers and descriptor loading
  // ------------------------------------------------------------
  wire fetchBeat = (state == pci_dma_pkg::ST_FETCH) && beatDone &&
                   !beatErr;
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      {sysAddr, pciAddr, count, chainAddr, descBase} <= '0;
      chainEnd <= 1'b0;
    end else begin
      if (wrSys) sysAddr <= mergeBytes(sysAddr, wDataQ, wStrbQ);
      else if (fetchBeat && descIdx == pci_dma_pkg::DESC_OFF_SYS[3:2])
        sysAddr <= rdWord;
      else if (inXfer && sysBeat && !beatErr)
        sysAddr <= sysAddr + pci_dma_pkg::WORD_BYTES;
      if (wrPci) pciAddr <= mergeBytes(pciAddr, wDataQ, wStrbQ);
      else if (fetchBeat && descIdx == pci_dma_pkg::DESC_OFF_PCI[3:2])
        pciAddr <= rdWord;
      else if (inXfer && pciBeat && !beatErr)
        pciAddr <= pciAddr + pci_dma_pkg::WORD_BYTES;
      if (wrCnt) count <= mergeBytes(count, wDataQ, wStrbQ);
      else if (fetchBeat && descIdx == pci_dma_pkg::DESC_OFF_CNT[3:2])
        count <= rdWord;
      else if ((state == pci_dma_pkg::ST_WRITE) && chunkDone)
        count <= count - {27'h0, chunkLen};
      if (wrChain) chainAddr <= chainNew;
      else if (fetchBeat && descIdx == pci_dma_pkg::DESC_OFF_LINK[3:2] &&
               rdWord != 32'h0)
        chainAddr <= rdWord;
      if (startChain) begin
        chainEnd <= 1'b0;
        descBase <= chainNew;
      end else if (fetchBeat &&
                   descIdx == pci_dma_pkg::DESC_OFF_LINK[3:2]) begin
        chainEnd <= (rdWord == 32'h0);
      end else if (finishEv && goFetch) begin
        descBase <= chainAddr;
      end
    end
  end

  // ------------------------------------------------------------
  // sequencer: fetch, read a chunk, then write it
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!resetn || ctrlRst || beatErr) begin
      state <= pci_dma_pkg::ST_IDLE;
      beat <= 5'h00;
      fifoCount <= 5'h00;
    end else begin
      case (state)
        pci_dma_pkg::ST_IDLE: begin
          beat <= 5'h00;
          if (startXfer) state <= pci_dma_pkg::ST_READ;
          else if (startChain) state <= pci_dma_pkg::ST_FETCH;
        end
        pci_dma_pkg::ST_FETCH: begin
          if (beatDone) begin
            beat <= lastBeat ? 5'h00 : beat + 5'h01;
            if (lastBeat) state <= pci_dma_pkg::ST_READ;
          end
        end
        pci_dma_pkg::ST_READ: begin
          if (zeroXfer) begin
            state <= goFetch ? pci_dma_pkg::ST_FETCH :
                               pci_dma_pkg::ST_IDLE;
          end else if (beatDone) begin
            fifoCount <= fifoCount + 5'h01;
            beat <= lastBeat ? 5'h00 : beat + 5'h01;
            if (lastBeat) state <= pci_dma_pkg::ST_WRITE;
          end
        end
        pci_dma_pkg::ST_WRITE: begin
          if (beatDone) begin
            fifoCount <= fifoCount - 5'h01;
            beat <= lastBeat ? 5'h00 : beat + 5'h01;
            if (finishEv)
              state <= goFetch ? pci_dma_pkg::ST_FETCH :
                                 pci_dma_pkg::ST_IDLE;
            else if (lastBeat) state <= pci_dma_pkg::ST_READ;
          end
        end
        default: state <= pci_dma_pkg::ST_IDLE;
      endcase
    end
  end

  // staging words between source and destination
  always_ff @(posedge clk_sys) begin
    if ((state == pci_dma_pkg::ST_READ) && beatDone && !beatErr)
      fifo[beat[3:0]] <= rdWord;
  end

  // ------------------------------------------------------------
  // bus masters
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      sysReq <= '0;
    end else if (sysBeat) begin
      sysReq.valid <= 1'b0;
    end else if (sysIssue) begin
      sysReq.valid <= 1'b1;
      sysReq.write <= (state == pci_dma_pkg::ST_WRITE);
      sysReq.burst <= (state == pci_dma_pkg::ST_FETCH) || burstMode;
      sysReq.last <= lastBeat;
      sysReq.addr <= (state == pci_dma_pkg::ST_FETCH) ?
          descBase + {25'h0, beat, 2'b00} : sysAddr;
      sysReq.wdata <= fifo[beat[3:0]];
    end
  end

  // four-phase: req up, ack up, req down, ack down
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      pciReq <= '0;
      pciWaitLow <= 1'b0;
    end else if (pciBeat) begin
      pciReq.req <= 1'b0;
      pciWaitLow <= 1'b1;
    end else begin
      if (!pciSync.ack) pciWaitLow <= 1'b0;
      if (pciIssue) begin
        pciReq.req <= 1'b1;
        pciReq.write <= (state == pci_dma_pkg::ST_WRITE);
        pciReq.last <= lastBeat;
        pciReq.addr <= pciAddr;
        pciReq.wdata <= fifo[beat[3:0]];
      end
    end
  end

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  sequence readChunkEnd;
    (state == pci_dma_pkg::ST_READ) && chunkDone;
  endsequence
  sequence writePhase;
    (state == pci_dma_pkg::ST_WRITE) && (fifoCount == chunkLen) && !busy == 0;
  endsequence

  start_xfer_a: assert property (startXfer |=>
    state == pci_dma_pkg::ST_READ && active)
    else $error("start did not enter read phase");
  xfer_done_a: assert property (finishEv |=> xDone)
    else $error("completion flag not set");
  irq_gate_a: assert property (irq |-> $past((xDone && xIe) ||
    (cDone && cIe) || ((|errBits) && eIe)))
    else $error("interrupt without enabled flag");
  err_abort_a: assert property (beatErr |=>
    state == pci_dma_pkg::ST_IDLE && errBits != 5'h0 && !active)
    else $error("error did not abort");
  chain_hold_a: assert property (fetchBeat && beat == 5'h00 &&
    rdWord == 32'h0 |=> $stable(chainAddr) && chainEnd)
    else $error("zero link changed chain address");
  chain_next_a: assert property (finishEv && goFetch |=>
    state == pci_dma_pkg::ST_FETCH && descBase == $past(chainAddr))
    else $error("next descriptor not fetched");
  chain_done_a: assert property (finishEv && chainRun && chainEnd |=>
    cDone && !chainRun)
    else $error("chain end not reported");
  bus_excl_a: assert property (!(sysReq.valid && pciReq.req))
    else $error("both buses requested at once");
  rd_to_wr_a: assert property (readChunkEnd |=> writePhase)
    else $error("write phase without full chunk");
  short_burst_a: assert property (inXfer && burstMode &&
    count < 32'h10 |-> chunkLen == count[4:0])
    else $error("final burst length wrong");

endmodule // pci_dma_chain_engine
`default_nettype wire

// *** core/pci_dma_pkg.sv ***
`default_nettype none
package pci_dma_pkg;

  // ------------------------------------------------------------
  // register map (byte addresses, one word each)
  // ------------------------------------------------------------
  localparam int REG_AW = 8;
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_SYSADDR = 8'h08;
  localparam logic [7:0] OFF_PCIADDR = 8'h0c;
  localparam logic [7:0] OFF_COUNT = 8'h10;
  localparam logic [7:0] OFF_CHAIN = 8'h14;

  // ------------------------------------------------------------
  // control and status fields
  // ------------------------------------------------------------
  localparam int CTRL_RST = 0;
  localparam int CTRL_DIR = 1;
  localparam int CTRL_MODE = 2;
  localparam int CTRL_ACT = 4;
  localparam int CTRL_XIE = 8;
  localparam int CTRL_CIE = 9;
  localparam int CTRL_EIE = 10;
  localparam logic CTRL_RST_INIT = 1'b1;
  localparam int ST_ERR_DATA = 0;
  localparam int ST_ERR_CHAIN = 1;
  localparam int ST_ERR_PCI = 2;
  localparam int ST_XDONE = 8;
  localparam int ST_CDONE = 9;

  localparam logic [1:0] MODE_SINGLE = 2'h0;
  localparam logic [1:0] MODE_BURST = 2'h1;
  localparam logic [4:0] FIFO_DEPTH = 5'h10;
  localparam logic [4:0] BURST_WORDS = 5'h10;
  localparam logic [4:0] SINGLE_WORDS = 5'h01;

  // descriptor word offsets
  localparam logic [3:0] DESC_OFF_LINK = 4'h0;
  localparam logic [3:0] DESC_OFF_SYS = 4'h4;
  localparam logic [3:0] DESC_OFF_PCI = 4'h8;
  localparam logic [3:0] DESC_OFF_CNT = 4'hc;
  localparam logic [4:0] DESC_LAST_BEAT = 5'h03;
  localparam logic [31:0] WORD_BYTES = 32'h0000_0004;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ------------------------------------------------------------
  // types
  // ------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_FETCH = 4'h2,
    ST_READ = 4'h4,
    ST_WRITE = 4'h8
  } dma_state_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic burst;
    logic last;
    logic [31:0] addr;
    logic [31:0] wdata;
  } sys_req_t;

  typedef struct packed {
    logic ack;
    logic err;
    logic [31:0] rdata;
  } sys_rsp_t;

  typedef struct packed {
    logic req;
    logic write;
    logic last;
    logic [31:0] addr;
    logic [31:0] wdata;
  } pci_req_t;

  // err: [2] fatal, [1] system error, [0] parity error
  typedef struct packed {
    logic clk;
    logic ack;
    logic [2:0] err;
    logic [31:0] rdata;
  } pci_in_t;

endpackage
`default_nettype wire

// *** testbench/dma_far_model.sv ***
`timescale 1ns/10ps
`default_nettype none
module dma_far_model (
  // clock
  input wire logic clk_sys,
  // buses
  input wire pci_dma_pkg::sys_req_t sysReq,
  output var pci_dma_pkg::sys_rsp_t sysRsp,
  input wire pci_dma_pkg::pci_req_t pciReq,
  output var pci_dma_pkg::pci_in_t pciIn,
  // fault injection
  input wire logic sysErr,
  input wire logic [2:0] pciErr
);
  logic [31:0] sysMem [0:127];
  logic [31:0] pciMem [0:63];
  logic pClk = 1'b0;
  logic pAck, sAck;
  logic [31:0] sData, pData;
  logic [2:0] pErr;
  // -----
  // memories
  // -----
  always #80 pClk = ~pClk;
  assign sysRsp = {sAck, sAck & sysErr, sData};
  assign pciIn = {pClk, pAck, pErr, pData};
  // read data is scrambled in the cycle after each ack
  always_ff @(posedge clk_sys) begin
    sAck <= sysReq.valid & ~sAck;
    sData <= sysMem[sysReq.addr[8:2]] ^ {32{sAck}};
    if (sysReq.valid & sAck & sysReq.write) begin
      sysMem[sysReq.addr[8:2]] <= sysReq.wdata;
    end
  end
  // ack follows req on pci edges, so four-phase by nature
  always_ff @(posedge pClk) begin
    pAck <= pciReq.req;
    pErr <= pciReq.req ? pciErr : 3'h0;
    pData <= pciReq.req ? pciMem[pciReq.addr[7:2]] : ~pData;
    if (pciReq.req & ~pAck & pciReq.write) begin
      pciMem[pciReq.addr[7:2]] <= pciReq.wdata;
    end
  end
endmodule // dma_far_model
`default_nettype wire

// *** testbench/pci_dma_chain_engine_tb_top.sv ***
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin \
  error_cnt++; $display("[FAIL] %0t got %h want %h", $time, g, e); end end
module pci_dma_chain_engine_tb_top;
  logic clk_sys, resetn, awValid, wValid, bReady, arValid, rReady;
  logic awReady, wReady, bValid, arReady, rValid, irq, sysErr;
  logic [7:0] awAddr, arAddr;
  logic [31:0] wData, rData, rd;
  logic [1:0] bResp, rResp, resp;
  logic [2:0] pciErr;
  pci_dma_pkg::sys_req_t sysReq;
  pci_dma_pkg::sys_rsp_t sysRsp;
  pci_dma_pkg::pci_req_t pciReq;
  pci_dma_pkg::pci_in_t pciIn;
  int error_cnt = 0;
  int check_count = 0;
  int overlap = 0;
  pci_dma_chain_engine i_pci_dma_chain_engine (.clk_sys(clk_sys),
    .resetn(resetn), .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid),
    .s_axi_awready(awReady), .s_axi_wdata(wData), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wValid), .s_axi_wready(wReady), .s_axi_bresp(bResp),
    .s_axi_bvalid(bValid), .s_axi_bready(bReady), .s_axi_araddr(arAddr),
    .s_axi_arvalid(arValid), .s_axi_arready(arReady), .s_axi_rdata(rData),
    .s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(rReady),
    .sysReq(sysReq), .sysRsp(sysRsp), .pciReq(pciReq), .pciIn(pciIn),
    .irq(irq));
  dma_far_model i_dma_far_model (.clk_sys(clk_sys), .sysReq(sysReq),
    .sysRsp(sysRsp), .pciReq(pciReq), .pciIn(pciIn), .sysErr(sysErr),
    .pciErr(pciErr));
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    if (sysReq.valid & pciReq.req) overlap++;
  end
  // -----
  // bus tasks
  // -----
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    awAddr <= a;
    wData <= d;
    awValid <= 1'b1;
    wValid <= 1'b1;
    bReady <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (awReady) awValid <= 1'b0;
      if (wReady) wValid <= 1'b0;
      resp = bResp;
    end while (bValid !== 1'b1);
    bReady <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic rdReg(input logic [7:0] a);
    arAddr <= a;
    arValid <= 1'b1;
    rReady <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (arReady) arValid <= 1'b0;
      rd = rData;
      resp = rResp;
    end while (rValid !== 1'b1);
    rReady <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic waitStat(input int b);
    do rdReg(pci_dma_pkg::OFF_STATUS);
    while (rd[b] !== 1'b1);
  endtask
  task automatic run(input logic [31:0] s, p, n, c);
    wr(pci_dma_pkg::OFF_STATUS, 32'h0000_031f);
    wr(pci_dma_pkg::OFF_SYSADDR, s);
    wr(pci_dma_pkg::OFF_PCIADDR, p);
    wr(pci_dma_pkg::OFF_COUNT, n);
    wr(pci_dma_pkg::OFF_CHAIN, 32'h0);
    wr(pci_dma_pkg::OFF_CTRL, c & 32'hffff_ffef);
    wr(pci_dma_pkg::OFF_CTRL, c);
  endtask
  task automatic conclude();
    $display("errors %0d checks %0d", error_cnt, check_count);
    if (error_cnt == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // -----
  // scenarios
  // -----
  task automatic tRegs();
    rdReg(pci_dma_pkg::OFF_CTRL);
    `CHK(rd[5:0], 6'h01)
    rdReg(8'h18);
    `CHK(resp, pci_dma_pkg::RESP_SLVERR)
    `CHK(rd, 32'h0)
    wr(8'h18, 32'h0);
    `CHK(resp, pci_dma_pkg::RESP_SLVERR)
  endtask
  task automatic tSingle();
    for (int i = 0; i < 3; i++) i_dma_far_model.sysMem[i] = 32'ha000_0000 + i;
    run(32'h0, 32'h40, 32'h3, 32'h110);
    waitStat(8);
    for (int i = 0; i < 3; i++)
      `CHK(i_dma_far_model.pciMem[16+i], 32'ha000_0000 + i)
    `CHK(irq, 1'b1)
  endtask
  task automatic tBurst();
    for (int i = 0; i < 18; i++) i_dma_far_model.pciMem[i] = 32'hb000_0000 + i;
    i_dma_far_model.sysMem[50] = 32'h5a5a_5a5a;
    run(32'h80, 32'h0, 32'h12, 32'h16);
    waitStat(8);
    for (int i = 0; i < 18; i++)
      `CHK(i_dma_far_model.sysMem[32+i], 32'hb000_0000 + i)
    `CHK(i_dma_far_model.sysMem[50], 32'h5a5a_5a5a)
    `CHK(irq, 1'b0)
    `CHK(overlap, 0)
  endtask
  task automatic tChain();
    // two chained descriptors, then a third one appended later
    logic [31:0] desc [12] = '{32'h110, 32'h180, 32'h80, 32'h1, 32'h0,
      32'h184, 32'h84, 32'h2, 32'h0, 32'h18c, 32'h8c, 32'h1};
    for (int i = 0; i < 4; i++)
      i_dma_far_model.sysMem[96+i] = 32'hc000_0000 + i;
    // 16-byte aligned, last link zero
    for (int i = 0; i < 12; i++)
      i_dma_far_model.sysMem[64+i] = desc[i];
    wr(pci_dma_pkg::OFF_STATUS, 32'h0000_031f);
    wr(pci_dma_pkg::OFF_COUNT, 32'h0);
    wr(pci_dma_pkg::OFF_CTRL, 32'h0000_0204);
    wr(pci_dma_pkg::OFF_CHAIN, 32'h100);
    rdReg(pci_dma_pkg::OFF_CTRL);
    `CHK(rd[5], 1'b1)
    waitStat(9);
    `CHK(rd[9:8], 2'b11)
    for (int i = 0; i < 3; i++)
      `CHK(i_dma_far_model.pciMem[32+i], 32'hc000_0000 + i)
    `CHK(irq, 1'b1)
    rdReg(pci_dma_pkg::OFF_CHAIN);
    `CHK(rd, 32'h110)
    // append: link the third descriptor, then check the running bit
    i_dma_far_model.sysMem[68] = 32'h120;
    rdReg(pci_dma_pkg::OFF_CTRL);
    `CHK(rd[5], 1'b0)
    if (rd[5] === 1'b0) begin
      rdReg(pci_dma_pkg::OFF_CHAIN);
      wr(pci_dma_pkg::OFF_STATUS, 32'h0000_031f);
      wr(pci_dma_pkg::OFF_CHAIN, i_dma_far_model.sysMem[rd[8:2]]);
    end
    waitStat(9);
    `CHK(i_dma_far_model.pciMem[35], 32'hc000_0003)
    rdReg(pci_dma_pkg::OFF_CHAIN);
    `CHK(rd, 32'h120)
  endtask
  task automatic tErr();
    logic [4:0] m;
    for (int k = 0; k < 4; k++) begin
      m = (k == 0) ? 5'h01 : 5'h01 << (k + 1);
      sysErr <= (k == 0);
      pciErr <= (k == 0) ? 3'h0 : 3'h1 << (k - 1);
      run(32'h0, 32'h0, 32'h1, 32'h410);
      waitStat((k == 0) ? 0 : k + 1);
      `CHK(rd[4:0], m)
      `CHK(rd[8], 1'b0)
      `CHK(irq, 1'b1)
    end
    sysErr <= 1'b0;
    pciErr <= 3'h0;
  endtask
  initial begin
    #300000;
    error_cnt++;
    conclude();
  end
  initial begin
    {resetn, awValid, wValid, bReady, arValid, rReady, sysErr} = 7'h0;
    {awAddr, arAddr, wData, pciErr} = 51'h0;
    repeat (16) @(posedge clk_sys);
    resetn <= 1'b1;
    @(posedge clk_sys);
    tRegs();
    tSingle();
    tBurst();
    tChain();
    tErr();
    conclude();
  end
endmodule // pci_dma_chain_engine_tb_top
`default_nettype wire
